/* File: logic/tmcc_pkg.sv */
package tmcc_pkg;
   localparam int NUM_CH = 7; // channel count
   localparam int CNT_W = 16; // timer count width
   localparam int ADDR_W = 8; // apb address width
   // register map (byte addresses)
   localparam logic [7:0] CH_STRIDE = 8'h08; // bytes per channel
   localparam logic [7:0] CTL_OFS = 8'h00; // channel_control_word
   localparam logic [7:0] CAP_OFS = 8'h04; // channel_capture_register
   localparam logic [7:0] STAT_ADDR = 8'h38; // event flags, write one to clear
   localparam logic [7:0] MASK_ADDR = 8'h3c; // channel irq enables
   // control word bit positions
   localparam int FLAG_BIT = 0; // channel_event_flag
   localparam int OVF_BIT = 1; // capture_overflow_bit
   localparam int IE_BIT = 2; // channel_irq_enable
   localparam int LVL_BIT = 3; // selected_input_state, read only
   localparam int CAPSEL_BIT = 4; // capture_select_bit
   localparam int SYNC_BIT = 5; // capture_sync_select
   localparam int EDGE_LO = 6; // capture_edge_lo
   localparam int EDGE_HI = 7; // capture_edge_hi
   localparam int INSEL_LO = 8; // input_select_lo
   localparam int INSEL_HI = 9; // input_select_hi
   // edge field codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // input select codes
   localparam logic [1:0] INSEL_A = 2'h0;
   localparam logic [1:0] INSEL_B = 2'h1;
   localparam logic [1:0] INSEL_GND = 2'h2;
   localparam logic [1:0] INSEL_VCC = 2'h3;
   // per-channel configuration carried to each channel
   typedef struct packed {
      logic [1:0] inSel; // input select field
      logic [1:0] edgeSel; // capture edge field
      logic syncSel; // synchronise to timer clock
      logic capSel; // capture mode when set
   } tmcc_ctl_t;
   localparam tmcc_ctl_t CTL_RST = '{inSel: INSEL_A, edgeSel: EDGE_NONE, syncSel: 1'b0, capSel: 1'b0};
   localparam logic [CNT_W-1:0] CAP_RST = 16'h0000; // capture register reset
endpackage

/* File: logic/tmcc_channel.sv */
`timescale 1ns/1ns
`default_nettype none
// one capture channel: input mux, edge detect, optional sync, capture latch
module tmcc_channel (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire tmcc_pkg::tmcc_ctl_t ctl,
   input wire logic srcA,
   input wire logic srcB,
   input wire logic timerClkEn,
   input wire logic [tmcc_pkg::CNT_W-1:0] timerCount,
   input wire logic capRead,
   output logic selLevel,
   output logic capEvent,
   output logic ovfEvent,
   output logic [tmcc_pkg::CNT_W-1:0] capValue
);
   logic prevLevel_r; // level seen last cycle
   logic pending_r; // synced capture waiting for timer tick
   logic unread_r; // capture data not yet read
   logic [tmcc_pkg::CNT_W-1:0] capValue_r; // channel_capture_register
   logic rise; // rising edge of selected input
   logic fall; // falling edge of selected input
   logic trig; // edge matches configured condition

   // input mux; ground/supply codes let software force edges
   always_comb begin
      unique case (ctl.inSel)
         tmcc_pkg::INSEL_A: selLevel = srcA;
         tmcc_pkg::INSEL_B: selLevel = srcB;
         tmcc_pkg::INSEL_GND: selLevel = 1'b0;
         tmcc_pkg::INSEL_VCC: selLevel = 1'b1;
      endcase
   end

   // edge history runs in both modes so entering capture mode is clean
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prevLevel_r <= 1'b0;
      end else begin
         prevLevel_r <= selLevel;
      end
   end

   assign rise = selLevel & ~prevLevel_r;
   assign fall = ~selLevel & prevLevel_r;
   // bit0 rising, bit1 falling; compare mode blocks all triggers
   assign trig = ctl.capSel & ((ctl.edgeSel[0] & rise) | (ctl.edgeSel[1] & fall));

   // synced path waits for the timer tick so count and capture never race
   assign capEvent = ctl.syncSel ? (ctl.capSel & timerClkEn & (pending_r | trig)) : trig;
   // a read in the same cycle consumes the old data, so no overflow
   assign ovfEvent = capEvent & unread_r & ~capRead;

   // pending synced trigger, dropped on leaving capture mode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_r <= 1'b0;
      end else if (!ctl.capSel || !ctl.syncSel || capEvent) begin
         pending_r <= 1'b0;
      end else if (trig) begin
         pending_r <= 1'b1;
      end
   end

   // capture latch and unread tracking
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capValue_r <= tmcc_pkg::CAP_RST;
         unread_r <= 1'b0;
      end else if (capEvent) begin
         capValue_r <= timerCount;
         unread_r <= 1'b1;
      end else if (capRead || !ctl.capSel) begin
         unread_r <= 1'b0;
      end
   end

   assign capValue = capValue_r;
endmodule
`default_nettype wire

/* File: logic/tmcc_top.sv */
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// seven capture channels behind an apb slave with a level interrupt
module tmcc_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   // apb slave
   input wire logic [tmcc_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer core
   input wire logic [tmcc_pkg::CNT_W-1:0] timerCount,
   input wire logic timerClkEn,
   input wire logic [tmcc_pkg::NUM_CH-1:0] cmpMatch,
   // capture sources
   input wire logic [tmcc_pkg::NUM_CH-1:0] captureSourceA,
   input wire logic [tmcc_pkg::NUM_CH-1:0] captureSourceB,
   // processor interrupt enable
   input wire logic globalIrqEnable,
   output logic irq
);
   localparam int N = tmcc_pkg::NUM_CH;

   tmcc_pkg::tmcc_ctl_t ctl_r [N]; // per-channel configuration
   logic [N-1:0] flag_r; // channel_event_flag, sticky
   logic [N-1:0] ovf_r; // capture_overflow_bit, sticky
   logic [N-1:0] mask_r; // channel_irq_enable
   logic [31:0] prdata_r; // read data, loaded in setup phase
   logic irq_r; // registered interrupt level
   logic [N-1:0] selLevel; // live selected input level
   logic [N-1:0] capEvent; // capture strobes
   logic [N-1:0] ovfEvent; // overflow strobes
   logic [N-1:0] capRead; // capture register read completes
   logic [tmcc_pkg::CNT_W-1:0] capValue [N]; // captured counts

   // address decode
   logic [2:0] chIdx; // channel addressed
   logic isChan; // inside the channel window
   logic isCap; // capture register rather than control word
   logic isStat; // status register
   logic isMask; // mask register
   logic badAddr; // unmapped or misaligned
   logic access; // access phase of any transfer
   logic wrAcc; // write takes effect this edge
   logic rdAcc; // read completes this edge
   logic [N-1:0] ctlWr; // write to a control word
   logic [N-1:0] flagClr; // software clears of event flags
   logic [N-1:0] ovfClr; // software clears of overflow bits

   assign chIdx = paddr[5:3];
   assign isChan = (paddr < tmcc_pkg::STAT_ADDR) && (paddr[1:0] == 2'h0);
   assign isCap = (paddr[2:0] == tmcc_pkg::CAP_OFS[2:0]);
   assign isStat = (paddr == tmcc_pkg::STAT_ADDR);
   assign isMask = (paddr == tmcc_pkg::MASK_ADDR);
   assign badAddr = !(isChan || isStat || isMask);
   assign access = psel & penable;
   assign wrAcc = access & pwrite & ~badAddr;
   assign rdAcc = access & ~pwrite & ~badAddr;

   // no wait states; unmapped addresses answer with an error, writes dropped
   assign pready = 1'b1;
   assign pslverr = access & badAddr;
   assign prdata = prdata_r;
   assign irq = irq_r;

   // per-channel strobes from the decode
   always_comb begin
      for (int i = 0; i < N; i++) begin
         ctlWr[i] = wrAcc & isChan & ~isCap & (chIdx == 3'(i));
         capRead[i] = rdAcc & isChan & isCap & (chIdx == 3'(i));
         flagClr[i] = (wrAcc & isStat & pwdata[i]) | (ctlWr[i] & pwdata[tmcc_pkg::FLAG_BIT]);
         ovfClr[i] = ctlWr[i] & pwdata[tmcc_pkg::OVF_BIT];
      end
   end

   // seven identical channels
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gCh
         tmcc_channel uCh (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .ctl(ctl_r[g]),
            .srcA(captureSourceA[g]),
            .srcB(captureSourceB[g]),
            .timerClkEn(timerClkEn),
            .timerCount(timerCount),
            .capRead(capRead[g]),
            .selLevel(selLevel[g]),
            .capEvent(capEvent[g]),
            .ovfEvent(ovfEvent[g]),
            .capValue(capValue[g])
         );
      end
   endgenerate

   // configuration fields of each control word
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < N; i++) begin
            ctl_r[i] <= tmcc_pkg::CTL_RST;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (ctlWr[i]) begin
               ctl_r[i].capSel <= pwdata[tmcc_pkg::CAPSEL_BIT];
               ctl_r[i].syncSel <= pwdata[tmcc_pkg::SYNC_BIT];
               ctl_r[i].edgeSel <= pwdata[tmcc_pkg::EDGE_HI:tmcc_pkg::EDGE_LO];
               ctl_r[i].inSel <= pwdata[tmcc_pkg::INSEL_HI:tmcc_pkg::INSEL_LO];
            end
         end
      end
   end

   // event flags: capture, or compare match in compare mode; set beats clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (capEvent[i] || (!ctl_r[i].capSel && cmpMatch[i])) begin
               flag_r[i] <= 1'b1;
            end else if (flagClr[i]) begin
               flag_r[i] <= 1'b0;
            end
         end
      end
   end

   // overflow bits stick until software writes a one to them
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (ovfEvent[i]) begin
               ovf_r[i] <= 1'b1;
            end else if (ovfClr[i]) begin
               ovf_r[i] <= 1'b0;
            end
         end
      end
   end

   // irq enables, reachable from the mask register or each control word
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= '0;
      end else if (wrAcc && isMask) begin
         mask_r <= pwdata[N-1:0];
      end else begin
         for (int i = 0; i < N; i++) begin
            if (ctlWr[i]) begin
               mask_r[i] <= pwdata[tmcc_pkg::IE_BIT];
            end
         end
      end
   end

   // interrupt needs an unmasked flag and the processor enable
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= globalIrqEnable & |(flag_r & mask_r);
      end
   end

   // read data captured in the setup phase, so it is stable through access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= 32'h0000_0000; // unmapped and reserved bits read zero
         if (isStat) begin
            prdata_r[N-1:0] <= flag_r;
         end else if (isMask) begin
            prdata_r[N-1:0] <= mask_r;
         end else if (isChan && isCap) begin
            prdata_r[tmcc_pkg::CNT_W-1:0] <= capValue[chIdx];
         end else if (isChan) begin
            prdata_r[tmcc_pkg::FLAG_BIT] <= flag_r[chIdx];
            prdata_r[tmcc_pkg::OVF_BIT] <= ovf_r[chIdx];
            prdata_r[tmcc_pkg::IE_BIT] <= mask_r[chIdx];
            prdata_r[tmcc_pkg::LVL_BIT] <= selLevel[chIdx];
            prdata_r[tmcc_pkg::CAPSEL_BIT] <= ctl_r[chIdx].capSel;
            prdata_r[tmcc_pkg::SYNC_BIT] <= ctl_r[chIdx].syncSel;
            prdata_r[tmcc_pkg::EDGE_HI:tmcc_pkg::EDGE_LO] <= ctl_r[chIdx].edgeSel;
            prdata_r[tmcc_pkg::INSEL_HI:tmcc_pkg::INSEL_LO] <= ctl_r[chIdx].inSel;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/tmcc_env_model.sv */
`timescale 1ns/1ns
`default_nettype none
// far side: timer core plus the wiring of both capture sources
module tmcc_env_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [6:0] levelA,
   input wire logic [6:0] levelB,
   output logic [6:0] captureSourceA,
   output logic [6:0] captureSourceB,
   output logic [15:0] timerCount,
   output logic timerClkEn
);
   logic [1:0] divCnt_r; // tick prescaler
   // sources follow the bench, already aligned to sys_clk
   assign captureSourceA = levelA;
   assign captureSourceB = levelB;
   // count moves every cycle so a capture one cycle late shows as a wrong value
   // the timer never halts here, so capture never needs stopping first
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timerCount <= 16'h0100;
         divCnt_r <= 2'h0;
      end else begin
         timerCount <= timerCount + 16'h0001;
         divCnt_r <= divCnt_r + 2'h1;
      end
   end
   assign timerClkEn = (divCnt_r == 2'h3); // one tick in four cycles
endmodule
`default_nettype wire

/* File: tb/tmcc_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// watches the apb slave and the interrupt pin
module tmcc_assertions (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic globalIrqEnable,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic badAdr; // outside the map or misaligned
   assign badAdr = (paddr > 8'h3c) || (paddr[1:0] != 2'h0);
   sequence s_acc; psel && penable; endsequence
   sequence s_rd; psel && penable && !pwrite; endsequence
   property p_rdy; pready; endproperty
   property p_errBad; s_acc ##0 badAdr |-> pslverr; endproperty
   property p_errOk; pslverr |-> psel && penable && badAdr; endproperty
   property p_rdBad; s_rd ##0 badAdr |-> prdata == 32'h0; endproperty
   property p_rdCtl; s_rd ##0 (!badAdr && paddr < 8'h38 && !paddr[2]) |-> prdata[31:10] == 22'h0; endproperty
   property p_rdCap; s_rd ##0 (!badAdr && paddr[2] && paddr < 8'h38) |-> prdata[31:16] == 16'h0; endproperty
   property p_rdStat; s_rd ##0 (paddr == 8'h38 || paddr == 8'h3c) |-> prdata[31:7] == 25'h0; endproperty
   property p_irqGie; !$past(globalIrqEnable) |-> !irq; endproperty
   // flags and mask only fall through writes, so a held enable keeps the request up
   property p_irqHold;
      irq && globalIrqEnable && !(psel && penable && pwrite) && !$past(psel && penable && pwrite) |=> irq;
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   a_errBad: assert property (p_errBad) else $error("no error on bad address");
   a_errOk: assert property (p_errOk) else $error("error outside bad access");
   a_rdBad: assert property (p_rdBad) else $error("bad address read not zero");
   a_rdCtl: assert property (p_rdCtl) else $error("control word high bits set");
   a_rdCap: assert property (p_rdCap) else $error("capture word high bits set");
   a_rdStat: assert property (p_rdStat) else $error("status or mask high bits set");
   a_irqGie: assert property (p_irqGie) else $error("irq without global enable");
   a_irqHold: assert property (p_irqHold) else $error("irq dropped without write");
endmodule
bind tmcc_top tmcc_assertions tmcc_assertions_inst (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .globalIrqEnable(globalIrqEnable), .irq(irq));
`default_nettype wire

/* File: tb/tb_tmcc_top.sv */
`timescale 1ns/1ns
`default_nettype none
// apb-driven checks of captures, flags, overflow and interrupt
module tb_tmcc_top;
   localparam logic [7:0] STA = 8'h38; // status register
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, timerClkEn, globalIrqEnable, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] timerCount, cntAfter, expCap;
   logic [6:0] cmpMatch, captureSourceA, captureSourceB, levelA, levelB;
   int err_total, total_checks, cycles;
   tmcc_top tmcc_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timerCount(timerCount), .timerClkEn(timerClkEn), .cmpMatch(cmpMatch), .captureSourceA(captureSourceA),
      .captureSourceB(captureSourceB), .globalIrqEnable(globalIrqEnable), .irq(irq));
   tmcc_env_model tmcc_env_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .levelA(levelA), .levelB(levelB),
      .captureSourceA(captureSourceA), .captureSourceB(captureSourceB), .timerCount(timerCount),
      .timerClkEn(timerClkEn));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer; returns just after the access edge with the count of the next cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      #1 cntAfter = timerCount;
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask
   // move source a of channel 0 and check flag and captured count
   task automatic edgeStep(input logic lvl, input logic hit);
      @(posedge sys_clk);
      levelA[0] <= lvl;
      #1 if (hit) expCap = timerCount;
      rdc("flag", STA, {31'h0, hit});
      rdc("cap", 8'h04, {16'h0, expCap});
      apb(1'b1, STA, 32'h1);
   endtask
   task automatic waitTick;
      do begin
         @(posedge sys_clk);
         #1;
      end while (timerClkEn !== 1'b1);
   endtask
   task automatic irqChk(input logic exp);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask
   task automatic results;
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         results;
      end
   end
   initial begin
      {rst_n, psel, penable, pwrite, globalIrqEnable, paddr, pwdata, cmpMatch, levelB} = '0;
      levelA = 7'h01;
      expCap = 16'h0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 7; c++) begin
         // channel 0 source a idles high, so its input-state bit reads one
         rdc("ctl", 8'(8 * c), (c == 0) ? 32'h8 : 32'h0);
         rdc("cap", 8'(8 * c + 4), 32'h0);
      end
      rdc("unmapped", 8'h40, 32'h0);
      // each select code, source a high and b low
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, 8'h00, 32'(s) << 8);
         rdc("level", 8'h00, (32'(s) << 8) | ((s == 0 || s == 3) ? 32'h8 : 32'h0));
      end
      apb(1'b1, 8'h00, 32'h0);
      @(posedge sys_clk);
      levelA[0] <= 1'b0;
      // every edge code against a rise and a fall
      for (int e = 0; e < 4; e++) begin
         apb(1'b1, 8'h00, 32'h10 | (32'(e) << 6));
         edgeStep(1'b1, e[0]);
         edgeStep(1'b0, e[1]);
      end
      // synchronised capture waits for the next timer tick
      apb(1'b1, 8'h00, 32'h70);
      waitTick;
      @(posedge sys_clk);
      levelA[0] <= 1'b1;
      waitTick;
      expCap = timerCount;
      rdc("sync cap", 8'h04, {16'h0, expCap});
      // software capture on all channels: ground then supply
      for (int c = 0; c < 7; c++) begin
         apb(1'b1, 8'(8 * c), 32'h2d0);
         apb(1'b1, 8'(8 * c), 32'h3d0);
         rdc("sw cap", 8'(8 * c + 4), {16'h0, cntAfter});
      end
      rdc("flags", STA, 32'h7f);
      apb(1'b1, 8'h30, 32'h2d0);
      apb(1'b1, 8'h30, 32'h3d0);
      // keep the count of the capture cycle before later transfers move cntAfter
      expCap = cntAfter;
      rdc("ovf", 8'h30, 32'h3db);
      rdc("cap", 8'h34, {16'h0, expCap});
      rdc("ovf hold", 8'h30, 32'h3db);
      apb(1'b1, 8'h30, 32'h3d2);
      rdc("ovf clr", 8'h30, 32'h3d9);
      apb(1'b1, 8'h30, 32'h2d0);
      rdc("no ovf", 8'h30, 32'h2d1);
      // compare mode ignores edges, takes match pulses
      apb(1'b1, 8'h30, 32'h0c0);
      apb(1'b1, STA, 32'h7f);
      @(posedge sys_clk);
      levelA[6] <= 1'b1;
      rdc("cmp edge", STA, 32'h0);
      @(posedge sys_clk);
      cmpMatch <= 7'h41;
      @(posedge sys_clk);
      cmpMatch <= 7'h00;
      rdc("match", STA, 32'h40);
      apb(1'b1, 8'h3c, 32'h40);
      rdc("mask", 8'h30, 32'h0cd);
      irqChk(1'b0);
      @(posedge sys_clk);
      globalIrqEnable <= 1'b1;
      irqChk(1'b1);
      apb(1'b1, 8'h3c, 32'h0);
      irqChk(1'b0);
      apb(1'b1, 8'h3c, 32'h40);
      irqChk(1'b1);
      apb(1'b1, STA, 32'h40);
      irqChk(1'b0);
      results;
   end
endmodule
`default_nettype wire
